// ===== design/rts_params.svh
// timing counts, register offsets and field positions of the sequencer
`ifndef RTS_PARAMS_SVH
`define RTS_PARAMS_SVH
`define CLK_FREQ_MHZ 50
`define PUD_TIME_US 72000
`define RC_TICK_NS 1000
`define PUD_TICKS (`PUD_TIME_US * 1000 / `RC_TICK_NS)
`define OST_CYCLES 1024
`define BOR_MIN_US 100
`define BOR_MIN_CYCLES (`BOR_MIN_US * `CLK_FREQ_MHZ)
`define OFS_CAUSE 5'h00
`define OFS_CORE_STATUS 5'h04
`define OFS_EV_STATUS 5'h08
`define OFS_EV_CLEAR 5'h0C
`define OFS_EV_ENABLE 5'h10
`define OFS_SEQ_STATE 5'h14
`define CAUSE_BOR_BIT 0
`define CAUSE_POR_BIT 1
`define STAT_TO_BIT 4
`define STAT_PD_BIT 3
`define EV_POR 0
`define EV_BOR 1
`define EV_WDT 2
`define EV_PIN 3
`define EV_RUN 4
`define EV_COUNT 5
`define MODE_LP 2'h0
`define MODE_XT 2'h1
`define MODE_HS 2'h2
`define MODE_RC 2'h3
`define VEC_RESET 13'h000
`define VEC_IRQ 13'h004
`endif

// ===== design/rts_pkg.sv
// types shared by the reset timeout sequencer
package rts_pkg;
  typedef enum logic [2:0] {
    S_HOLD, S_POWER_UP_DELAY_TIMER, S_OST, S_PIN, S_RUN, S_SLEEP
  } seq_state_t;
  typedef enum logic [2:0] {
    SEL_CAUSE, SEL_CORE, SEL_EVST, SEL_EVCLR, SEL_EVEN, SEL_STATE, SEL_NONE
  } reg_sel_t;
endpackage

// ===== design/edge_counter.sv
// counts rising edges of an asynchronous tick pin up to a terminal count
`timescale 1ns/1ns
`default_nettype none
module edge_counter #(
  parameter int unsigned TERMINAL = 1024
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic run_in,
  output logic done_out
);
  localparam int W = $clog2(TERMINAL + 1);
  logic [2:0] sync;
  logic [W-1:0] count;
  logic rise;

  // two flops before use, third only keeps history for the edge
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      sync <= 3'h0;
    else
      sync <= {sync[1:0], pin_in};

  assign rise = sync[1] & ~sync[2];

  // dropping run clears the count, so a restart always runs in full
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      count <= '0;
    else if (!run_in)
      count <= '0;
    else if (rise && !done_out)
      count <= count + 1'b1;

  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
      done_out <= 1'b0;
    else if (!run_in)
      done_out <= 1'b0;
    else if (rise && count == W'(TERMINAL - 1))
      done_out <= 1'b1;

  a_done_at_count: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $rose(done_out) |-> count == W'(TERMINAL))
    else $error("done raised before terminal count");
endmodule
`default_nettype wire

// ===== design/reset_timeout_sequencer.sv
// reset timeout sequencer: power-up delay, oscillator settle, brown-out
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "rts_params.svh"
// Function
// - after power-on the delay timer runs a nominal 72 ms on RC ticks
// - chip held in reset while delay runs; a config bit enables it
// - after the delay, or at once if disabled, count 1024 oscillator edges
// - settle count only in crystal modes, after power-on, brown-out or wake
// - enabled brown-out resets after supply low longer than 100 us
// - after brown-out, hold until supply recovers, then run full delay
// - brown-out during the delay restarts it once supply recovers
// - brown-out enable forces the power-up delay on
// - delay enable is active low; mode table sets delay and count
// - leave reset at end of settle count, or of delay if no count
// - delays expire under a low reset pin; release runs at once
// - cause bit 0 cleared by brown-out, set by software
// - cause bit 1 cleared on power-on only, set by software
// - expiry and power-down flags follow the reset and wake cause
// - resets restart at 000h; wake at next address or 0004h
// - power-on core status reads 0001 1xxx, low bits zero here
module reset_timeout_sequencer
  import rts_pkg::*;
#(
  parameter int unsigned PUD_TICKS = `PUD_TICKS,
  parameter int unsigned OST_CYCLES = `OST_CYCLES,
  parameter int unsigned BOR_MIN_CYCLES = `BOR_MIN_CYCLES
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic por_detect_in,
  input wire logic brownout_low_in,
  input wire logic external_reset_pin_n_in,
  input wire logic rc_tick_in,
  input wire logic oscillator_input_pin_in,
  input wire logic [1:0] osc_mode_in,
  input wire logic brownout_detect_enable_in,
  input wire logic power_up_delay_enable_n_in,
  input wire logic sleep_enter_in,
  input wire logic wake_irq_in,
  input wire logic watchdog_expire_in,
  input wire logic global_irq_enable_in,
  input wire logic [12:0] sleep_pc_in,
  output logic core_reset_out,
  output logic restart_load_out,
  output logic [12:0] restart_vector_out,
  output logic watchdog_expiry_flag_out,
  output logic power_down_flag_out,
  output logic irq_out
);
  localparam int BW = $clog2(BOR_MIN_CYCLES + 1);
  logic [1:0] rst_sync;
  logic rst_n;
  logic [6:0] pin_s1, pin_s2;
  logic por_s, bo_low, pin_high, bor_en, power_up_delay_timer_en_n;
  logic [1:0] mode;
  logic xtal, power_up_delay_timer_eff, power_up_delay_timer_done, ost_done, bor_trip, waking;
  logic [BW-1:0] bor_cnt;
  seq_state_t state, next_state;
  logic [1:0] cause;
  logic [`EV_COUNT-1:0] ev_status, ev_enable, ev_set;
  logic wait_q, req, wake_ev;
  reg_sel_t sel;
  logic [7:0] core_view;

  // reset release through two flops
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  assign rst_n = rst_sync[1];

  // pins and config straps are asynchronous; config is static in use
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
    begin
      pin_s1 <= 7'h00;
      pin_s2 <= 7'h00;
    end
    else
    begin
      pin_s1 <= {por_detect_in, brownout_low_in, external_reset_pin_n_in,
        brownout_detect_enable_in, power_up_delay_enable_n_in, osc_mode_in};
      pin_s2 <= pin_s1;
    end
  assign {por_s, bo_low, pin_high, bor_en, power_up_delay_timer_en_n, mode} = pin_s2;

  // settle count applies only to the crystal modes
  assign xtal = (mode != `MODE_RC);
  // brown-out enable overrides the active low delay enable
  assign power_up_delay_timer_eff = !power_up_delay_timer_en_n || bor_en;

  // brown-out qualifier: a dip shorter than the minimum is ignored
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      bor_cnt <= '0;
    else if (!(bor_en && bo_low))
      bor_cnt <= '0;
    else if (bor_cnt != BW'(BOR_MIN_CYCLES))
      bor_cnt <= bor_cnt + 1'b1;
  assign bor_trip = bor_en && bo_low && bor_cnt == BW'(BOR_MIN_CYCLES - 1);

  // delay timer counts RC ticks only, never the main clock
  edge_counter #(.TERMINAL(PUD_TICKS)) u_power_up_delay_timer (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .pin_in(rc_tick_in),
    .run_in(state == S_POWER_UP_DELAY_TIMER),
    .done_out(power_up_delay_timer_done)
  );

  // settle counter counts edges of the oscillator pin
  edge_counter #(.TERMINAL(OST_CYCLES)) u_ost (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n),
    .pin_in(oscillator_input_pin_in),
    .run_in(state == S_OST),
    .done_out(ost_done)
  );

  assign wake_ev = wake_irq_in || watchdog_expire_in;

  // sequence: power-on and brown-out win over everything else
  always_comb
  begin
    next_state = state;
    case (state)
      S_HOLD:
        if (!(bor_en && bo_low))
          next_state = power_up_delay_timer_eff ? S_POWER_UP_DELAY_TIMER : (xtal ? S_OST : S_PIN);
      S_POWER_UP_DELAY_TIMER:
        if (power_up_delay_timer_done)
          next_state = xtal ? S_OST : S_PIN;
      S_OST:
        if (ost_done)
          next_state = waking ? S_RUN : S_PIN;
      S_PIN:
        if (pin_high)
          next_state = S_RUN;
      S_RUN:
        if (!pin_high || watchdog_expire_in)
          next_state = S_PIN;
        else if (sleep_enter_in)
          next_state = S_SLEEP;
      S_SLEEP:
        if (!pin_high)
          next_state = S_PIN;
        else if (wake_ev)
          next_state = xtal ? S_OST : S_RUN;
      default:
        next_state = S_HOLD;
    endcase
    if (por_s || bor_trip || (state == S_HOLD && bor_en && bo_low))
      next_state = S_HOLD;
  end

  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      state <= S_HOLD;
    else
      state <= next_state;

  // waking marks a settle count entered from sleep, not from reset
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      waking <= 1'b0;
    else if (state == S_SLEEP && next_state == S_OST)
      waking <= 1'b1;
    else if (next_state != S_OST)
      waking <= 1'b0;

  // core held in reset outside run and sleep
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      core_reset_out <= 1'b1;
    else
      core_reset_out <= !(next_state == S_RUN || next_state == S_SLEEP);

  // restart address loads when the core starts running again
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
    begin
      restart_load_out <= 1'b0;
      restart_vector_out <= `VEC_RESET;
    end
    else
    begin
      restart_load_out <= next_state == S_RUN && state != S_RUN;
      if (next_state == S_HOLD || next_state == S_PIN)
        restart_vector_out <= `VEC_RESET;
      else if (state == S_SLEEP && wake_ev)
        restart_vector_out <= (wake_irq_in && global_irq_enable_in) ?
          `VEC_IRQ : sleep_pc_in + 13'h001;
    end

  // expiry and power-down flags; sleep entry sets expiry, clears power-down
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
    begin
      watchdog_expiry_flag_out <= 1'b1;
      power_down_flag_out <= 1'b1;
    end
    else if (por_s || bor_trip)
    begin
      watchdog_expiry_flag_out <= 1'b1;
      power_down_flag_out <= 1'b1;
    end
    else if (state == S_RUN && pin_high && watchdog_expire_in)
    begin
      watchdog_expiry_flag_out <= 1'b0;
      power_down_flag_out <= 1'b1;
    end
    else if (state == S_SLEEP && pin_high && watchdog_expire_in)
    begin
      watchdog_expiry_flag_out <= 1'b0;
      power_down_flag_out <= 1'b0;
    end
    else if (state == S_SLEEP && (!pin_high || wake_irq_in))
    begin
      watchdog_expiry_flag_out <= 1'b1;
      power_down_flag_out <= 1'b0;
    end
    else if (state == S_RUN && sleep_enter_in && pin_high)
    begin
      watchdog_expiry_flag_out <= 1'b1;
      power_down_flag_out <= 1'b0;
    end

  assign core_view = {3'h0, watchdog_expiry_flag_out,
    power_down_flag_out, 3'h0};

  // bus slave: one wait cycle on every access, then the answer
  function automatic reg_sel_t decode(input logic [4:0] a);
    if (a == `OFS_CAUSE)
      decode = SEL_CAUSE;
    else if (a == `OFS_CORE_STATUS)
      decode = SEL_CORE;
    else if (a == `OFS_EV_STATUS)
      decode = SEL_EVST;
    else if (a == `OFS_EV_CLEAR)
      decode = SEL_EVCLR;
    else if (a == `OFS_EV_ENABLE)
      decode = SEL_EVEN;
    else if (a == `OFS_SEQ_STATE)
      decode = SEL_STATE;
    else
      decode = SEL_NONE;
  endfunction

  assign req = avs_read_in || avs_write_in;
  assign sel = decode(avs_address_in);

  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      wait_q <= 1'b1;
    else
      wait_q <= !(req && wait_q);
  assign avs_waitrequest_out = wait_q;

  // read data captured in the wait cycle, stands on the answer edge
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && wait_q)
    begin
      if (sel == SEL_CAUSE)
        avs_readdata_out <= {30'h0, cause};
      else if (sel == SEL_CORE)
        avs_readdata_out <= {24'h0, core_view};
      else if (sel == SEL_EVST)
        avs_readdata_out <= {27'h0, ev_status};
      else if (sel == SEL_EVEN)
        avs_readdata_out <= {27'h0, ev_enable};
      else if (sel == SEL_STATE)
        avs_readdata_out <= {29'h0, state};
      else
        avs_readdata_out <= 32'h0000_0000;
    end

  // cause bits: hardware clears, software sets; hardware wins a tie
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      cause <= 2'h0;
    else
    begin
      if (avs_write_in && !wait_q && decode(avs_address_in) == SEL_CAUSE)
        cause <= avs_writedata_in[1:0];
      if (por_s)
        cause[`CAUSE_POR_BIT] <= 1'b0;
      if (bor_trip)
        cause[`CAUSE_BOR_BIT] <= 1'b0;
    end

  always_comb
  begin
    ev_set = '0;
    ev_set[`EV_POR] = por_s;
    ev_set[`EV_BOR] = bor_trip;
    ev_set[`EV_WDT] = state == S_RUN && watchdog_expire_in;
    ev_set[`EV_PIN] = (state == S_RUN || state == S_SLEEP) && !pin_high;
    ev_set[`EV_RUN] = next_state == S_RUN && state != S_RUN;
  end

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      ev_status <= '0;
    else if (avs_write_in && !wait_q && sel == SEL_EVCLR)
      ev_status <= (ev_status & ~avs_writedata_in[`EV_COUNT-1:0]) | ev_set;
    else
      ev_status <= ev_status | ev_set;

  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      ev_enable <= '0;
    else if (avs_write_in && !wait_q && sel == SEL_EVEN)
      ev_enable <= avs_writedata_in[`EV_COUNT-1:0];

  always_ff @(posedge mclk_in or negedge rst_n)
    if (!rst_n)
      irq_out <= 1'b0;
    else
      irq_out <= |(ev_status & ev_enable);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n);

  a_hold_in_delay: assert property (state == S_POWER_UP_DELAY_TIMER |-> core_reset_out)
    else $error("core left reset during power-up delay");
  a_delay_bypass: assert property (state == S_HOLD && !bo_low && !por_s &&
    !power_up_delay_timer_eff && xtal |=> state == S_OST)
    else $error("settle count not entered with delay disabled");
  a_rc_no_settle: assert property (state == S_POWER_UP_DELAY_TIMER && power_up_delay_timer_done && !xtal &&
    !por_s && !bor_trip |=> state == S_PIN)
    else $error("RC mode entered settle count");
  a_bor_forces_delay: assert property (state == S_HOLD && bor_en &&
    !bo_low && !por_s |=> state == S_POWER_UP_DELAY_TIMER)
    else $error("brown-out enable did not force the delay");
  a_bor_min_time: assert property (bor_trip |-> $past(bo_low, 2) &&
    bor_cnt == BW'(BOR_MIN_CYCLES - 1))
    else $error("brown-out tripped early");
  a_bor_hold: assert property (bor_trip |=> state == S_HOLD ##1
    core_reset_out)
    else $error("brown-out did not hold reset");
  a_delay_restart: assert property (state == S_POWER_UP_DELAY_TIMER && bor_trip |=>
    state == S_HOLD ##1 !power_up_delay_timer_done)
    else $error("delay not restarted by brown-out");
  a_pin_release: assert property (state == S_PIN && pin_high && !por_s &&
    !bor_trip |=> state == S_RUN ##1 !core_reset_out)
    else $error("pin release did not start execution");
  a_settle_exit: assert property (state == S_OST && ost_done && !waking &&
    !por_s && !bor_trip |=> state == S_PIN)
    else $error("settle count end did not end reset timing");
  a_por_cause: assert property (por_s |=> !cause[`CAUSE_POR_BIT] &&
    core_view == 8'h18)
    else $error("power-on status pattern wrong");
  a_bor_cause: assert property (bor_trip |=> !cause[`CAUSE_BOR_BIT] &&
    watchdog_expiry_flag_out && power_down_flag_out)
    else $error("brown-out cause not recorded");
  a_wake_vector: assert property (state == S_SLEEP && pin_high &&
    wake_irq_in && global_irq_enable_in && !por_s && !bor_trip |=>
    restart_vector_out == `VEC_IRQ)
    else $error("interrupt wake vector wrong");
  a_bus_one_wait: assert property (req && wait_q |=> !avs_waitrequest_out)
    else $error("bus answer late");

  c_delay_done: cover property (state == S_POWER_UP_DELAY_TIMER && power_up_delay_timer_done);
  c_bor_restart: cover property (state == S_POWER_UP_DELAY_TIMER && bor_trip);
  c_wake_run: cover property (state == S_OST && waking && ost_done);
endmodule
`default_nettype wire

// ===== dv/core_model.sv
// behavioural processor core and external reset pin beside the sequencer
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic mclk_in,
  input wire logic core_reset_in,
  output logic sleep_enter_out,
  output logic wake_irq_out,
  output logic watchdog_expire_out,
  output logic global_irq_enable_out,
  output logic [12:0] sleep_pc_out,
  output logic external_reset_pin_n_out
);
  // idle core with the pin released high
  initial
  begin
    sleep_enter_out = 1'b0;
    wake_irq_out = 1'b0;
    watchdog_expire_out = 1'b0;
    global_irq_enable_out = 1'b0;
    sleep_pc_out = 13'h000;
    external_reset_pin_n_out = 1'b1;
  end

  // one-cycle event pulse: 0 sleep, 1 interrupt wake, 2 watchdog
  task automatic pulse(input int kind, input logic [12:0] pc);
    begin
      @(posedge mclk_in);
      sleep_pc_out <= pc;
      sleep_enter_out <= (kind == 0);
      wake_irq_out <= (kind == 1);
      watchdog_expire_out <= (kind == 2);
      @(posedge mclk_in);
      sleep_enter_out <= 1'b0;
      wake_irq_out <= 1'b0;
      watchdog_expire_out <= 1'b0;
    end
  endtask

  // pin held low may outlast every delay; release is the start signal
  task automatic set_pin(input logic v);
    begin
      @(posedge mclk_in);
      external_reset_pin_n_out <= v;
    end
  endtask

  // interrupt enable level decides the wake vector
  task automatic set_gie(input logic v);
    begin
      @(posedge mclk_in);
      global_irq_enable_out <= v;
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the reset timeout sequencer
`timescale 1ns/1ns
`default_nettype none
`include "rts_params.svh"
module testbench;
  logic mclk, arst_n, rd, wr, por, bor_low, rc_tick, osc, bor_en, pud_n;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [1:0] mode;
  logic wreq, core_reset, rload, to_flag, pd_flag, irq;
  logic sleep_en, wake, wdt, global_irq_enable, pin_n;
  logic [12:0] rvec, spc;
  int failures = 0;
  int checks = 0;
  int n;

  // short counts keep the run brief; bounds below derive from them
  reset_timeout_sequencer #(.PUD_TICKS(4), .OST_CYCLES(8),
    .BOR_MIN_CYCLES(4)) u_dut (
    .mclk_in(mclk), .arst_n_in(arst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .por_detect_in(por), .brownout_low_in(bor_low),
    .external_reset_pin_n_in(pin_n), .rc_tick_in(rc_tick),
    .oscillator_input_pin_in(osc), .osc_mode_in(mode),
    .brownout_detect_enable_in(bor_en),
    .power_up_delay_enable_n_in(pud_n), .sleep_enter_in(sleep_en),
    .wake_irq_in(wake), .watchdog_expire_in(wdt),
    .global_irq_enable_in(global_irq_enable), .sleep_pc_in(spc),
    .core_reset_out(core_reset), .restart_load_out(rload),
    .restart_vector_out(rvec), .watchdog_expiry_flag_out(to_flag),
    .power_down_flag_out(pd_flag), .irq_out(irq));

  core_model u_core (
    .mclk_in(mclk), .core_reset_in(core_reset),
    .sleep_enter_out(sleep_en), .wake_irq_out(wake),
    .watchdog_expire_out(wdt), .global_irq_enable_out(global_irq_enable),
    .sleep_pc_out(spc), .external_reset_pin_n_out(pin_n));

  // main clock plus slow rc ticks (400 ns) and oscillator (40 ns)
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    rc_tick = 1'b0;
    forever #200 rc_tick = ~rc_tick;
  end
  initial
  begin
    osc = 1'b0;
    forever #20 osc = ~osc;
  end

  task automatic end_sim();
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    begin
      checks++;
      if (got !== exp)
      begin
        failures++;
        $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask

  // one bus access held until waitrequest is seen low; data lands in q
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int k;
    begin
      k = 0;
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      rd <= ~w;
      wr <= w;
      do
      begin
        @(posedge mclk);
        k++;
      end
      while (wreq !== 1'b0 && k < 50);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      chk("bus answer", 1, k < 50);
    end
  endtask

  // counts cycles to the restart pulse; hc asks for reset held meanwhile
  task automatic wait_load(input logic hc);
    logic held;
    begin
      n = 0;
      held = 1'b1;
      do
      begin
        @(posedge mclk);
        n++;
        if (rload !== 1'b1 && core_reset !== 1'b1)
          held = 1'b0;
      end
      while (rload !== 1'b1 && n < 3000);
      chk("restart seen", 1, n < 3000);
      if (hc)
        chk("held in reset", 1, held);
    end
  endtask

  // config only changes while the power-on detector holds the sequence
  task automatic por_pulse(input logic [1:0] m, input logic p,
    input logic b);
    begin
      @(posedge mclk);
      mode <= m;
      pud_n <= p;
      bor_en <= b;
      por <= 1'b1;
      repeat (5) @(posedge mclk);
      por <= 1'b0;
    end
  endtask

  task automatic t_power_on();
    begin
      por_pulse(`MODE_RC, 1'b0, 1'b0);
      wait_load(1'b1);
      chk("rc delay", 1, n >= 60);
      chk("por vector", `VEC_RESET, rvec);
      chk("por flags", 2'h3, {to_flag, pd_flag});
      bus(1'b0, `OFS_CORE_STATUS, 0);
      chk("core status", 32'h18, q);
      bus(1'b0, `OFS_CAUSE, 0);
      chk("cause por bit", 0, q & 32'h2);
      por_pulse(`MODE_RC, 1'b1, 1'b0);
      wait_load(1'b1);
      chk("rc no delay", 1, n < 12);
      for (int m = 0; m < 3; m++)
      begin
        por_pulse(m[1:0], 1'b1, 1'b0);
        wait_load(1'b1);
        chk("settle only", 1, n >= 14 && n < 50);
      end
      por_pulse(`MODE_XT, 1'b0, 1'b0);
      wait_load(1'b1);
      chk("delay and settle", 1, n >= 74);
      por_pulse(`MODE_HS, 1'b1, 1'b1);
      wait_load(1'b1);
      chk("forced delay", 1, n >= 74);
    end
  endtask

  task automatic t_brownout();
    begin
      bus(1'b1, `OFS_CAUSE, 32'h3);
      bus(1'b0, `OFS_CAUSE, 0);
      chk("cause write", 32'h3, q);
      @(posedge mclk);
      bor_low <= 1'b1;
      repeat (3) @(posedge mclk);
      bor_low <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("short dip", 0, core_reset);
      bor_low <= 1'b1;
      repeat (20) @(posedge mclk);
      chk("brownout hold", 1, core_reset);
      bor_low <= 1'b0;
      repeat (30) @(posedge mclk);
      bor_low <= 1'b1;
      repeat (10) @(posedge mclk);
      bor_low <= 1'b0;
      wait_load(1'b1);
      chk("restarted delay", 1, n >= 74);
      repeat (2) @(posedge mclk);
      chk("bor flags", 2'h3, {to_flag, pd_flag});
      bus(1'b0, `OFS_CAUSE, 0);
      chk("cause after bor", 32'h2, q);
    end
  endtask

  task automatic t_pin_hold();
    begin
      u_core.set_pin(1'b0);
      por_pulse(`MODE_XT, 1'b0, 1'b0);
      repeat (200) @(posedge mclk);
      chk("pin hold", 1, core_reset);
      bus(1'b0, `OFS_SEQ_STATE, 0);
      chk("pin wait state", 3, q);
      u_core.set_pin(1'b1);
      wait_load(1'b1);
      chk("start on release", 1, n < 10);
    end
  endtask

  task automatic t_sleep_wake();
    begin
      for (int k = 0; k < 3; k++)
      begin
        u_core.set_gie(k == 0);
        u_core.pulse(0, 13'h123);
        repeat (3) @(posedge mclk);
        chk("sleep flags", 2'h2, {to_flag, pd_flag});
        bus(1'b0, `OFS_SEQ_STATE, 0);
        chk("sleep state", 5, q);
        u_core.pulse(k == 2 ? 2 : 1, 13'h123);
        wait_load(1'b0);
        chk("wake settle", 1, n >= 14);
        chk("wake vector", k == 0 ? `VEC_IRQ : 13'h124, rvec);
        repeat (2) @(posedge mclk);
        chk("wake flags", k == 2 ? 0 : 2, {to_flag, pd_flag});
      end
      u_core.pulse(2, 13'h000);
      wait_load(1'b0);
      chk("wdt reset", 1, n < 10);
      chk("wdt vector", `VEC_RESET, rvec);
      repeat (2) @(posedge mclk);
      chk("wdt flags", 2'h1, {to_flag, pd_flag});
      por_pulse(`MODE_RC, 1'b1, 1'b0);
      wait_load(1'b1);
      u_core.pulse(0, 13'h050);
      repeat (3) @(posedge mclk);
      u_core.pulse(1, 13'h050);
      wait_load(1'b0);
      chk("rc wake fast", 1, n < 10);
    end
  endtask

  task automatic t_regs_irq();
    begin
      bus(1'b1, `OFS_EV_ENABLE, 0);
      bus(1'b1, `OFS_EV_CLEAR, 32'h1F);
      u_core.pulse(2, 13'h000);
      wait_load(1'b0);
      repeat (3) @(posedge mclk);
      bus(1'b0, `OFS_EV_STATUS, 0);
      chk("events", 32'h14, q);
      chk("irq masked", 0, irq);
      bus(1'b1, `OFS_EV_ENABLE, 32'h10);
      bus(1'b0, `OFS_EV_ENABLE, 0);
      chk("enable reg", 32'h10, q);
      repeat (2) @(posedge mclk);
      chk("irq raised", 1, irq);
      bus(1'b1, `OFS_EV_CLEAR, 32'h10);
      repeat (2) @(posedge mclk);
      chk("irq cleared", 0, irq);
      bus(1'b0, `OFS_EV_STATUS, 0);
      chk("events left", 32'h04, q);
      bus(1'b0, 5'h18, 0);
      chk("unmapped", 0, q);
      bus(1'b1, `OFS_CORE_STATUS, 32'hFF);
      bus(1'b0, `OFS_CORE_STATUS, 0);
      chk("status read only", 32'h08, q);
    end
  endtask

  // reset for 20 cycles, then each scenario in turn
  initial
  begin
    arst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    por = 1'b1;
    bor_low = 1'b0;
    bor_en = 1'b0;
    pud_n = 1'b0;
    mode = `MODE_RC;
    addr = 5'h00;
    wdata = 32'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_power_on();
    t_brownout();
    t_pin_hold();
    t_sleep_wake();
    t_regs_irq();
    end_sim();
  end

  // a hang anywhere ends the run as a mismatch
  initial
  begin
    #400000;
    failures++;
    end_sim();
  end
endmodule
`default_nettype wire
